// *** src/pomux_pkg.sv ***
// constants for the eight-pin port with function multiplexing
package pomux_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_OUTPUT_LATCH = 16'h7F44;
  localparam logic [15:0] IDX_PIN_INPUT = 16'h7F45;
  localparam logic [15:0] IDX_DIRECTION_CONTROL = 16'h7F46;
  localparam logic [15:0] IDX_FUNCTION_SELECT_A = 16'h7F47;
  localparam logic [15:0] IDX_FUNCTION_SELECT_B = 16'h7FF1;
  localparam logic [17:0] ADDR_OUTPUT_LATCH = {IDX_OUTPUT_LATCH, 2'h0};
  localparam logic [17:0] ADDR_PIN_INPUT = {IDX_PIN_INPUT, 2'h0};
  localparam logic [17:0] ADDR_DIRECTION_CONTROL =
    {IDX_DIRECTION_CONTROL, 2'h0};
  localparam logic [17:0] ADDR_FUNCTION_SELECT_A =
    {IDX_FUNCTION_SELECT_A, 2'h0};
  localparam logic [17:0] ADDR_FUNCTION_SELECT_B =
    {IDX_FUNCTION_SELECT_B, 2'h0};
  // reset values
  localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION_CONTROL = 8'h00;
  localparam logic [7:0] RST_FUNCTION_SELECT_A = 8'h00;
  localparam logic [7:0] RST_FUNCTION_SELECT_B = 8'h00;
  // pin numbers of the multiplexed functions
  localparam int PIN_SERIAL_DATA_IN = 1;
  localparam int PIN_SERIAL_CLOCK = 2;
  localparam int PIN_ASYNC_ZERO_RX = 4;
  localparam int PIN_ASYNC_TWO_RX = 6;
  // level a peripheral input sees while no pin feeds it
  localparam logic PERIPH_IDLE = 1'h1;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : pomux_pkg

// *** src/pomux_port.sv ***
// eight-pin port with function multiplexing behind an axi4-lite slave
`timescale 1ns/1ps

// How it works
// [R1] eight pins, each pin's direction taken from its direction bit under select 00
// [R2] pin input register returns current pin levels, inverted under the inverted-input settings
// [R3] inverted-input settings invert read data and the peripheral input
// [R4] select 00: float, pull-up, or drive latch by direction and latch
// [R5] select 01: slow latch drive, drive low, or open with inverted read
// [R6] select 10: low, inverted peripheral, peripheral, or high
// [R7] select 11: slow low, slow peripheral, open drain peripheral, or open
// [R8] pin 0 carries serial data out, feeds no peripheral input
// [R9] pin 1 carries serial data out, feeds serial data in when A set
// [R10] pin 2 carries serial clock out, feeds serial clock in when A set
// [R11] pin 3 carries async channel zero transmit, feeds nothing
// [R12] pin 4 carries timer low, feeds async zero receive only at 1111
// [R13] pin 5 carries timer high output, feeds no peripheral input
// [R14] pin 6 has no output function, feeds async two receive at A,B,dir
// [R15] pin 7 carries async channel two transmit, feeds nothing
// [R16] reset clears latch, direction and both selects: pins float
// [R17] pad state is frozen while any standby mode is active
// [R18] slow-edge and open-drain controls go to the pad per pin
module pomux_port (
  input wire logic clk_sys,
  input wire logic resetn,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pads
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  output logic [7:0] pin_slow_edge,
  output logic [7:0] pin_open_drain,
  // low-power standby indication, any of the three modes
  input wire logic standby_active,
  // peripheral outputs
  input wire logic serial_channel_zero_data_out,
  input wire logic serial_channel_zero_clock_out,
  input wire logic async_channel_zero_tx,
  input wire logic timer_three_low_out,
  input wire logic timer_three_high_out,
  input wire logic async_channel_two_tx,
  // peripheral inputs
  output logic serial_channel_zero_data_in,
  output logic serial_channel_zero_clock_in,
  output logic async_channel_zero_rx,
  output logic async_channel_two_rx
);

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] fsa;
    logic [7:0] fsb;
    logic [7:0] pin_q;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pu;
    logic [7:0] pad_slow;
    logic [7:0] pad_od;
    logic [3:0] per_in;
    logic aw_held;
    logic [31:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pomux_state_t;
  pomux_state_t s_reg;
  pomux_state_t s_next;

  logic [7:0] periph_out;
  logic [7:0] inv_c;
  logic [7:0] out_c;
  logic [7:0] oe_c;
  logic [7:0] pu_c;
  logic [7:0] slow_c;
  logic [7:0] od_c;
  logic [7:0] read_c;
  // pins that feed peripheral inputs
  localparam int PIN_SERIAL_DATA_IN = pomux_pkg::PIN_SERIAL_DATA_IN;
  localparam int PIN_SERIAL_CLOCK = pomux_pkg::PIN_SERIAL_CLOCK;
  localparam int PIN_ASYNC_ZERO_RX = pomux_pkg::PIN_ASYNC_ZERO_RX;
  localparam int PIN_ASYNC_TWO_RX = pomux_pkg::PIN_ASYNC_TWO_RX;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin decode of select a, select b, latch and direction
  // peripheral output each pin offers; pin 6 has none and acts as high
  assign periph_out = {async_channel_two_tx, 1'h1, timer_three_high_out,
    timer_three_low_out, async_channel_zero_tx,
    serial_channel_zero_clock_out, serial_channel_zero_data_out,
    serial_channel_zero_data_out}; // [R8] [R9] [R10] [R11] [R13] [R14] [R15]

  // drive, enable, pull-up, slow, open drain and read inversion
  always_comb
  begin
    for (int k = 0; k < 8; k++)
    begin
      out_c[k] = 1'h0;
      oe_c[k] = 1'h0;
      pu_c[k] = 1'h0;
      slow_c[k] = 1'h0;
      od_c[k] = 1'h0;
      inv_c[k] = 1'h0;
      case ({s_reg.fsa[k], s_reg.fsb[k]})
        2'h0:
        begin
          // float, pull-up or plain drive
          oe_c[k] = s_reg.dir[k]; // [R1] [R4]
          out_c[k] = s_reg.latch[k]; // [R4]
          pu_c[k] = ~s_reg.dir[k] & s_reg.latch[k]; // [R4]
        end
        2'h1:
        begin
          // slow latch drive as input, else low or open with inverted read
          out_c[k] = ~s_reg.dir[k] & s_reg.latch[k]; // [R5]
          oe_c[k] = ~s_reg.dir[k] | ~s_reg.latch[k]; // [R5]
          slow_c[k] = ~s_reg.dir[k]; // [R18]
          inv_c[k] = s_reg.dir[k] & s_reg.latch[k]; // [R3] [R5]
        end
        2'h2:
        begin
          oe_c[k] = 1'h1; // [R6]
          case ({s_reg.latch[k], s_reg.dir[k]})
            2'h0: out_c[k] = 1'h0;
            2'h2:
            begin
              out_c[k] = ~periph_out[k]; // [R6]
              inv_c[k] = 1'h1; // [R3]
            end
            2'h1: out_c[k] = periph_out[k]; // [R6]
            default: out_c[k] = 1'h1;
          endcase
        end
        default:
        begin
          case ({s_reg.latch[k], s_reg.dir[k]})
            2'h0:
            begin
              oe_c[k] = 1'h1; // [R7]
              slow_c[k] = 1'h1; // [R18]
            end
            2'h2:
            begin
              out_c[k] = periph_out[k]; // [R7]
              oe_c[k] = 1'h1;
              slow_c[k] = 1'h1; // [R18]
            end
            2'h1:
            begin
              // pull low only, release for a high
              oe_c[k] = ~periph_out[k]; // [R7]
              od_c[k] = 1'h1; // [R18]
            end
            default: oe_c[k] = 1'h0; // [R7]
          endcase
        end
      endcase
    end
  end

  // read data from the pins, inverted where configured
  assign read_c = s_reg.pin_q ^ inv_c; // [R2] [R3]

  ////////////////////////////////////////////////////////////////////////////
  // next state: registers, pads, peripheral inputs and bus
  always_comb
  begin
    logic wr_ok;
    logic [17:0] wa;
    logic [17:0] ra;
    logic rhi;
    s_next = s_reg;
    wr_ok = 1'h0;
    wa = s_reg.aw_addr[17:0];
    ra = s_axi_araddr[17:0];
    rhi = |s_axi_araddr[31:18];
    // pin levels sampled every cycle
    s_next.pin_q = pin_in; // [R2]
    // pads keep their state during standby
    if (!standby_active)
    begin
      s_next.pad_out = out_c; // [R17]
      s_next.pad_oe = oe_c; // [R1]
      s_next.pad_pu = pu_c;
      s_next.pad_slow = slow_c; // [R18]
      s_next.pad_od = od_c; // [R18]
    end
    // peripheral inputs
    s_next.per_in[0] = s_reg.fsa[PIN_SERIAL_DATA_IN] ?
      read_c[PIN_SERIAL_DATA_IN] : pomux_pkg::PERIPH_IDLE; // [R9] [R3]
    s_next.per_in[1] = s_reg.fsa[PIN_SERIAL_CLOCK] ?
      read_c[PIN_SERIAL_CLOCK] : pomux_pkg::PERIPH_IDLE; // [R10] [R3]
    s_next.per_in[2] = (s_reg.fsa[PIN_ASYNC_ZERO_RX] &
      s_reg.fsb[PIN_ASYNC_ZERO_RX] & s_reg.latch[PIN_ASYNC_ZERO_RX] &
      s_reg.dir[PIN_ASYNC_ZERO_RX]) ? read_c[PIN_ASYNC_ZERO_RX] :
      pomux_pkg::PERIPH_IDLE; // [R12]
    s_next.per_in[3] = (s_reg.fsa[PIN_ASYNC_TWO_RX] &
      s_reg.fsb[PIN_ASYNC_TWO_RX] & s_reg.dir[PIN_ASYNC_TWO_RX]) ?
      read_c[PIN_ASYNC_TWO_RX] : pomux_pkg::PERIPH_IDLE; // [R14]
    // write address and data taken in either order
    if (s_axi_awvalid && s_reg.awready)
    begin
      s_next.aw_held = 1'h1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready)
    begin
      s_next.w_held = 1'h1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_lane0 = s_axi_wstrb[0];
    end
    // write once both halves are held and no response is pending
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid)
    begin
      s_next.aw_held = 1'h0;
      s_next.w_held = 1'h0;
      s_next.bvalid = 1'h1;
      wr_ok = ~|s_reg.aw_addr[31:18];
      if (wr_ok)
      begin
        case (wa)
          pomux_pkg::ADDR_OUTPUT_LATCH:
            if (s_reg.w_lane0) s_next.latch = s_reg.w_data;
          pomux_pkg::ADDR_DIRECTION_CONTROL:
            if (s_reg.w_lane0) s_next.dir = s_reg.w_data; // [R1]
          pomux_pkg::ADDR_FUNCTION_SELECT_A:
            if (s_reg.w_lane0) s_next.fsa = s_reg.w_data;
          pomux_pkg::ADDR_FUNCTION_SELECT_B:
            if (s_reg.w_lane0) s_next.fsb = s_reg.w_data;
          pomux_pkg::ADDR_PIN_INPUT: wr_ok = 1'h1;
          default: wr_ok = 1'h0;
        endcase
      end
      s_next.bresp = wr_ok ? pomux_pkg::RESP_OKAY : pomux_pkg::RESP_DECERR;
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'h0;
    s_next.awready = ~s_next.aw_held & ~s_next.bvalid;
    s_next.wready = ~s_next.w_held & ~s_next.bvalid;
    // read channel
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'h0;
    if (s_axi_arvalid && s_reg.arready)
    begin
      s_next.rvalid = 1'h1;
      s_next.rdata = 32'h0000_0000;
      s_next.rresp = pomux_pkg::RESP_OKAY;
      if (rhi)
        s_next.rresp = pomux_pkg::RESP_DECERR;
      else
      begin
        case (ra)
          pomux_pkg::ADDR_OUTPUT_LATCH: s_next.rdata[7:0] = s_reg.latch;
          pomux_pkg::ADDR_PIN_INPUT: s_next.rdata[7:0] = read_c; // [R2]
          pomux_pkg::ADDR_DIRECTION_CONTROL: s_next.rdata[7:0] = s_reg.dir;
          pomux_pkg::ADDR_FUNCTION_SELECT_A: s_next.rdata[7:0] = s_reg.fsa;
          pomux_pkg::ADDR_FUNCTION_SELECT_B: s_next.rdata[7:0] = s_reg.fsb;
          default: s_next.rresp = pomux_pkg::RESP_DECERR;
        endcase
      end
    end
    s_next.arready = ~s_next.rvalid;
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s_reg <= '0;
      s_reg.latch <= pomux_pkg::RST_OUTPUT_LATCH; // [R16]
      s_reg.dir <= pomux_pkg::RST_DIRECTION_CONTROL; // [R16]
      s_reg.fsa <= pomux_pkg::RST_FUNCTION_SELECT_A; // [R16]
      s_reg.fsb <= pomux_pkg::RST_FUNCTION_SELECT_B; // [R16]
      s_reg.per_in <= 4'hF;
    end
    else
      s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign pin_out = s_reg.pad_out;
  assign pin_oe = s_reg.pad_oe;
  assign pin_pullup = s_reg.pad_pu;
  assign pin_slow_edge = s_reg.pad_slow;
  assign pin_open_drain = s_reg.pad_od;
  assign serial_channel_zero_data_in = s_reg.per_in[0];
  assign serial_channel_zero_clock_in = s_reg.per_in[1];
  assign async_channel_zero_rx = s_reg.per_in[2];
  assign async_channel_two_rx = s_reg.per_in[3];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_pin_input;
    s_rd_taken ##0 (s_axi_araddr == {14'h0000, pomux_pkg::ADDR_PIN_INPUT});
  endsequence
  property p_reset_float;
    disable iff (1'b0)
    !resetn |=> (pin_oe == 8'h00 && pin_pullup == 8'h00);
  endproperty
  a_reset_float: assert property (p_reset_float) // [R16]
    else $error("pins not floating after reset");
  property p_pullup;
    !standby_active |=> pin_pullup ==
      $past(~s_reg.fsa & ~s_reg.fsb & ~s_reg.dir & s_reg.latch);
  endproperty
  a_pullup: assert property (p_pullup) // [R4]
    else $error("pull-up enable does not follow settings");
  property p_plain_drive;
    logic [7:0] m;
    (!standby_active, m = ~s_reg.fsa & ~s_reg.fsb & s_reg.dir) |=>
      ((pin_oe & m) == m) && ((pin_out & m) == ($past(s_reg.latch) & m));
  endproperty
  a_plain_drive: assert property (p_plain_drive) // [R1]
    else $error("output pin not driving latch value");
  property p_standby_hold;
    standby_active |=> $stable(pin_oe) && $stable(pin_out) &&
      $stable(pin_pullup);
  endproperty
  a_standby_hold: assert property (p_standby_hold) // [R17]
    else $error("pad state changed in standby");
  property p_read_pins;
    s_rd_pin_input |=> s_axi_rvalid &&
      s_axi_rdata[7:0] == $past(s_reg.pin_q ^ inv_c);
  endproperty
  a_read_pins: assert property (p_read_pins) // [R2]
    else $error("pin input read wrong");
  property p_inv_read;
    s_rd_pin_input ##0 (s_reg.fsa[0] && !s_reg.fsb[0] && s_reg.latch[0] &&
      !s_reg.dir[0]) |=> s_axi_rdata[0] == !$past(s_reg.pin_q[0]);
  endproperty
  a_inv_read: assert property (p_inv_read) // [R3]
    else $error("inverted input not inverted");
  property p_serial_in;
    s_reg.fsa[1] |=> serial_channel_zero_data_in ==
      $past(s_reg.pin_q[1] ^ inv_c[1]);
  endproperty
  a_serial_in: assert property (p_serial_in) // [R9]
    else $error("serial data input not fed from pin 1");
  property p_async0_gate;
    !(s_reg.fsa[4] && s_reg.fsb[4] && s_reg.latch[4] && s_reg.dir[4])
      |=> async_channel_zero_rx;
  endproperty
  a_async0_gate: assert property (p_async0_gate) // [R12]
    else $error("async zero receive fed outside full setting");
  property p_open_drain;
    !standby_active && s_reg.fsa[3] && s_reg.fsb[3] && !s_reg.latch[3] &&
      s_reg.dir[3] |=> pin_open_drain[3] &&
      pin_oe[3] == !$past(async_channel_zero_tx) && !pin_out[3];
  endproperty
  a_open_drain: assert property (p_open_drain) // [R7]
    else $error("open drain drive wrong on pin 3");
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before taken");
endmodule : pomux_port

// *** bench/pomux_pad_model.sv ***
// pad model: pin levels from device drive, outside drive and pull-ups
`timescale 1ns/1ps
module pomux_pad_model (
  input wire logic clk_sys,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] level
);
  logic [7:0] last_reg = 8'h00;
  // device drive wins, then outside drive, pull-up, else a toggling float
  always_comb
  begin
    for (int k = 0; k < 8; k++)
    begin
      if (pin_oe[k])
        level[k] = pin_out[k];
      else if (ext_en[k])
        level[k] = ext_val[k];
      else if (pin_pullup[k])
        level[k] = 1'b1;
      else
        level[k] = ~last_reg[k];
    end
  end
  // remember the level so a float never repeats it
  always_ff @(posedge clk_sys)
    last_reg <= level;
endmodule : pomux_pad_model

// *** bench/tb_port_one_pin_mux.sv ***
// self-checking bench for the eight-pin port with function multiplexing
`timescale 1ns/1ps
module tb_port_one_pin_mux;
  logic clk_sys, resetn, standby_active;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, pin_slow_edge;
  logic [7:0] pin_open_drain, ext_val, ext_en;
  logic [5:0] p_o;
  logic [3:0] p_i;
  int mismatches = 0;
  int check_count = 0;
  localparam logic [17:0] A_LAT = pomux_pkg::ADDR_OUTPUT_LATCH;
  localparam logic [17:0] A_IN = pomux_pkg::ADDR_PIN_INPUT;
  localparam logic [17:0] A_DIR = pomux_pkg::ADDR_DIRECTION_CONTROL;
  localparam logic [1:0] OK = pomux_pkg::RESP_OKAY;
  localparam logic [1:0] DE = pomux_pkg::RESP_DECERR;

  pomux_port u_pomux_port (
    .clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
    .pin_pullup, .pin_slow_edge, .pin_open_drain, .standby_active,
    .serial_channel_zero_data_out(p_o[0]),
    .serial_channel_zero_clock_out(p_o[1]),
    .async_channel_zero_tx(p_o[2]), .timer_three_low_out(p_o[3]),
    .timer_three_high_out(p_o[4]), .async_channel_two_tx(p_o[5]),
    .serial_channel_zero_data_in(p_i[0]),
    .serial_channel_zero_clock_in(p_i[1]),
    .async_channel_zero_rx(p_i[2]), .async_channel_two_rx(p_i[3])
  );
  pomux_pad_model u_pomux_pad_model (
    .clk_sys, .pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_en,
    .level(pin_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock, 4 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_n(int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_n

  // bus write: address and data offered together, each dropped when taken
  task automatic wr(logic [17:0] a, logic [7:0] d, logic [1:0] er);
    bit ad;
    bit dd;
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr <= {14'h0000, a};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1)
        ad = 1'b1;
      if (s_axi_wready === 1'b1)
        dd = 1'b1;
      if (ad)
        s_axi_awvalid <= 1'b0;
      if (dd)
        s_axi_wvalid <= 1'b0;
    end
    do
      @(posedge clk_sys);
    while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  // bus read: response checked at the edge where rvalid is sampled
  task automatic rd(logic [17:0] a, logic [7:0] e, logic [1:0] er);
    s_axi_araddr <= {14'h0000, a};
    s_axi_arvalid <= 1'b1;
    do
      @(posedge clk_sys);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge clk_sys);
    while (s_axi_rvalid !== 1'b1);
    chk("rdata", {24'h0, e}, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd

  task automatic cfg(logic [7:0] fa, fb, lt, dr);
    wr(pomux_pkg::ADDR_FUNCTION_SELECT_A, fa, OK);
    wr(pomux_pkg::ADDR_FUNCTION_SELECT_B, fb, OK);
    wr(A_LAT, lt, OK);
    wr(A_DIR, dr, OK);
    wait_n(3);
  endtask : cfg

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(A_LAT, pomux_pkg::RST_OUTPUT_LATCH, OK);
    rd(A_DIR, pomux_pkg::RST_DIRECTION_CONTROL, OK);
    rd(pomux_pkg::ADDR_FUNCTION_SELECT_A, 8'h00, OK);
    rd(pomux_pkg::ADDR_FUNCTION_SELECT_B, 8'h00, OK);
    chk("oe", 32'h0, {24'h0, pin_oe | pin_pullup});
  endtask : t_reset

  task automatic t_plain;
    cfg(8'h00, 8'h00, 8'hF5, 8'h0F);
    chk("oe", 32'h0F, {24'h0, pin_oe});
    chk("out", 32'h05, {24'h0, pin_out & pin_oe});
    chk("pullup", 32'hF0, {24'h0, pin_pullup});
    ext_en <= 8'hF0;
    ext_val <= 8'hA0;
    wait_n(3);
    rd(A_IN, 8'hA5, OK);
  endtask : t_plain

  task automatic t_inv;
    ext_val <= 8'h5A;
    ext_en <= 8'hFF;
    cfg(8'h00, 8'hFF, 8'hFF, 8'hFF);
    chk("oe", 32'h0, {24'h0, pin_oe});
    rd(A_IN, 8'hA5, OK);
    cfg(8'h00, 8'hFF, 8'hFF, 8'h00);
    chk("out", 32'hFF, {24'h0, pin_out & pin_oe});
    chk("slow", 32'hFF, {24'h0, pin_slow_edge});
  endtask : t_inv

  task automatic t_periph;
    ext_en <= 8'h00;
    p_o <= 6'b010110;
    cfg(8'hFF, 8'h00, 8'h00, 8'hFF);
    chk("oe", 32'hFF, {24'h0, pin_oe});
    chk("out", 32'h6C, {24'h0, pin_out});
    chk("pin_in", 32'h6C, {24'h0, pin_in});
    chk("periph_in", 32'hE, {28'h0, p_i});
    cfg(8'hFF, 8'h00, 8'hFF, 8'h00);
    chk("out", 32'h93, {24'h0, pin_out & pin_oe});
    rd(A_IN, 8'h6C, OK);
    chk("periph_in", 32'hE, {28'h0, p_i});
  endtask : t_periph

  task automatic t_rx;
    ext_val <= 8'h00;
    ext_en <= 8'hFF;
    cfg(8'hFF, 8'hFF, 8'hFF, 8'hFF);
    chk("oe", 32'h0, {24'h0, pin_oe});
    chk("rx", 32'h0, {30'h0, p_i[3:2]});
    wr(A_DIR, 8'hEF, OK);
    wait_n(3);
    chk("rx", 32'h1, {30'h0, p_i[3:2]});
    chk("slow", 32'h1, {31'h0, pin_slow_edge[4]});
    wr(A_DIR, 8'hFF, OK);
    wr(A_LAT, 8'h00, OK);
    wait_n(3);
    chk("od", 32'h1, {31'h0, pin_open_drain[0]});
    chk("od_oe", 32'h1, {31'h0, pin_oe[0]});
  endtask : t_rx

  task automatic t_standby;
    cfg(8'h00, 8'h00, 8'h00, 8'hFF);
    standby_active <= 1'b1;
    wr(A_DIR, 8'h00, OK);
    wait_n(3);
    chk("oe", 32'hFF, {24'h0, pin_oe});
    standby_active <= 1'b0;
    wait_n(3);
    chk("oe", 32'h0, {24'h0, pin_oe});
  endtask : t_standby

  task automatic t_bus;
    wr(A_IN, 8'hFF, OK);
    wr(18'h00000, 8'h33, DE);
    rd(18'h00000, 8'h00, DE);
    rd(A_LAT, 8'h00, OK);
    // lane 0 strobe off: write answered, latch untouched
    s_axi_wstrb <= 4'h0;
    wr(A_LAT, 8'h5A, OK);
    s_axi_wstrb <= 4'hF;
    rd(A_LAT, 8'h00, OK);
  endtask : t_bus

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    mismatches++;
    final_report();
  end

  // main sequence
  initial
  begin
    resetn = 1'b0;
    standby_active = 1'b0;
    {s_axi_awvalid, s_axi_wvalid} = 2'h0;
    s_axi_arvalid = 1'b0;
    // responses are always accepted, so ready never toggles between calls
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    ext_val = 8'h00;
    ext_en = 8'h00;
    p_o = 6'h00;
    wait_n(12);
    resetn <= 1'b1;
    wait_n(1);
    t_reset();
    t_plain();
    t_inv();
    t_periph();
    t_rx();
    t_standby();
    t_bus();
    final_report();
  end
endmodule : tb_port_one_pin_mux
